// file: design/sfch_front.sv
// serial flash command front end with pause, write latch and rx fifo
`timescale 1ns/1ps
`default_nettype none
`include "sfch_consts.svh"
module sfch_front #(
  parameter logic [7:0]  MAKER_ID   = 8'h5a,   // arbitrary value
  parameter logic [15:0] PART_ID    = 16'h1234, // arbitrary value
  parameter logic [7:0]  SIG_ID     = 8'h33,   // arbitrary value
  parameter int          FIFO_DEPTH = `SFCH_FIFO_DEPTH
) (
  input  wire logic                 i_sys_clk,   // 100 MHz clock
  input  wire logic                 i_srst,      // sync reset, high
  input  wire sfch_pkg::sfch_pins_t i_pins,      // raw serial pins
  input  wire logic [7:0]           i_status,    // backend status byte
  input  wire logic                 i_op_busy,   // backend op running
  input  wire logic                 i_op_done,   // backend op finished
  input  wire logic [7:0]           i_rd_data,   // byte at o_rd_addr
  input  wire logic                 i_rx_ready,  // rx consumer ready
  output logic                      o_so,        // serial out level
  output logic                      o_so_oe,     // serial out enable
  output logic                      o_write_latch_flag, // write latch
  output logic                      o_hold_active, // pause in force
  output logic                      o_op_start,  // command accepted
  output sfch_pkg::sfch_op_t        o_op,        // accepted command
  output logic [23:0]               o_rd_addr,   // array read address
  output logic                      o_rx_valid,  // rx byte valid
  output logic [7:0]                o_rx_data,   // rx byte
  output logic                      o_overrun    // rx byte lost
);
  import sfch_pkg::*;

  // -----------------------------------------------------------------
  // decoding helpers
  // -----------------------------------------------------------------
  // bytes before output starts, zero for commands with no output
  function automatic logic [2:0] out_start(input logic [7:0] op);
    unique case (op)
      `SFCH_STATUS_READ_CMD, `SFCH_JEDEC_IDENT_CMD: out_start = 3'h1;
      `SFCH_READ_CMD, `SFCH_MAKER_PART_ID_CMD,
      `SFCH_WAKE_CMD:                             out_start = 3'h4;
      `SFCH_FAST_READ_CMD, `SFCH_TWO_LINE_READ_CMD: out_start = 3'h5;
      default:                                    out_start = 3'h0;
    endcase
  endfunction

  // bytes an executing command must have, zero if it never executes
  function automatic logic [2:0] exec_len(input logic [7:0] op);
    unique case (op)
      `SFCH_LATCH_SET_CMD, `SFCH_LATCH_CLEAR_CMD, `SFCH_CHIP_WIPE_CMD_A,
      `SFCH_CHIP_WIPE_CMD_B, `SFCH_DEEP_SLEEP_CMD,
      `SFCH_WAKE_CMD:          exec_len = 3'h1;
      `SFCH_STATUS_WRITE_CMD:  exec_len = 3'h2;
      `SFCH_SMALL_WIPE_CMD, `SFCH_BLOCK_WIPE_CMD_A,
      `SFCH_BLOCK_WIPE_CMD_B:  exec_len = 3'h4;
      `SFCH_PAGE_WRITE_CMD:    exec_len = 3'h5;
      default:                 exec_len = 3'h0;
    endcase
  endfunction

  function automatic logic is_modify(input logic [7:0] op);
    is_modify = (op == `SFCH_STATUS_WRITE_CMD) ||
                (op == `SFCH_SMALL_WIPE_CMD) ||
                (op == `SFCH_BLOCK_WIPE_CMD_A) ||
                (op == `SFCH_BLOCK_WIPE_CMD_B) ||
                (op == `SFCH_CHIP_WIPE_CMD_A) ||
                (op == `SFCH_CHIP_WIPE_CMD_B) ||
                (op == `SFCH_PAGE_WRITE_CMD);
  endfunction

  // -----------------------------------------------------------------
  // pin synchronisers; edges come from the second and third stage
  // -----------------------------------------------------------------
  logic [3:0] pin_m;
  logic [3:0] pin_s;
  logic [3:0] pin_d;
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      pin_m <= `SFCH_PINS_IDLE;
      pin_s <= `SFCH_PINS_IDLE;
      pin_d <= `SFCH_PINS_IDLE;
    end else begin
      pin_m <= i_pins;
      pin_s <= pin_m;
      pin_d <= pin_s;
    end
  end

  wire cs_s      = pin_s[3];
  wire sclk_s    = pin_s[2];
  wire si_s      = pin_s[1];
  wire hold_s    = pin_s[0];
  wire cs_rise   = cs_s && !pin_d[3];
  wire cs_fall   = !cs_s && pin_d[3];
  wire sclk_rise = sclk_s && !pin_d[2];
  wire sclk_fall = !sclk_s && pin_d[2];

  // -----------------------------------------------------------------
  // pause control
  // -----------------------------------------------------------------
  sfch_state_t state;
  sfch_state_t next_state;
  always_comb begin
    next_state = state;
    unique case (state)
      SFCH_RUN: begin
        if (!cs_s && !hold_s && !sclk_s) begin
          next_state = SFCH_PAUSE;
        end
      end
      SFCH_PAUSE: begin
        if (cs_s) begin
          next_state = SFCH_RUN;
        end else if (hold_s && !sclk_s) begin
          next_state = SFCH_RUN;
        end
      end
    endcase
  end

  // clock edges count only while selected and not paused
  wire live      = !cs_s && (state == SFCH_RUN);
  wire bit_rise  = live && sclk_rise;
  wire bit_fall  = live && sclk_fall;

  // -----------------------------------------------------------------
  // input shifter and byte framing
  // -----------------------------------------------------------------
  logic [2:0]  bit_cnt;
  logic [2:0]  byte_cnt;
  logic [6:0]  shift;
  logic [7:0]  opcode;
  logic [23:0] addr;
  wire  [7:0]  rx_byte   = {shift, si_s};
  wire         byte_done = bit_rise && (bit_cnt == 3'h7);
  wire  [2:0]  first_out = out_start(opcode);
  wire         out_phase = (first_out != 3'h0) && (byte_cnt >= first_out);
  wire  [2:0]  out_idx   = byte_cnt - first_out;

  always_ff @(posedge i_sys_clk) begin
    if (i_srst || cs_s) begin
      bit_cnt  <= '0;
      byte_cnt <= '0;
      shift    <= '0;
    end else if (bit_rise) begin
      bit_cnt  <= bit_cnt + 3'h1;
      shift    <= rx_byte[6:0];
      if (byte_done && byte_cnt != 3'h7) begin
        byte_cnt <= byte_cnt + 3'h1;
      end
    end
  end

  // address bytes arrive high byte first
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      opcode <= '0;
      addr   <= '0;
    end else if (byte_done && byte_cnt == 3'h0) begin
      opcode <= rx_byte;
    end else if (byte_done && byte_cnt <= 3'h3) begin
      addr   <= {addr[15:0], rx_byte};
    end
  end

  wire is_read = (opcode == `SFCH_READ_CMD) ||
                 (opcode == `SFCH_FAST_READ_CMD) ||
                 (opcode == `SFCH_TWO_LINE_READ_CMD);

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_rd_addr <= '0;
    end else if (byte_done && byte_cnt == 3'h3) begin
      o_rd_addr <= {addr[15:0], rx_byte};
    end else if (byte_done && out_phase && is_read) begin
      o_rd_addr <= o_rd_addr + 24'h1;
    end
  end

  // -----------------------------------------------------------------
  // output byte selection and serial out
  // -----------------------------------------------------------------
  // busy passes straight through: a pause never halts the backend
  wire [7:0] status_byte = {i_status[7:2], o_write_latch_flag,
                            i_op_busy};
  wire       part_first  = out_idx[0] ^ addr[0];
  wire [7:0] ident_byte  = (out_idx == 3'h0) ? MAKER_ID :
                           (out_idx == 3'h1) ? PART_ID[15:8] : PART_ID[7:0];
  wire [7:0] out_byte =
    (opcode == `SFCH_STATUS_READ_CMD)   ? status_byte :
    (opcode == `SFCH_JEDEC_IDENT_CMD)   ? ident_byte :
    (opcode == `SFCH_MAKER_PART_ID_CMD) ? (part_first ? PART_ID[7:0]
                                                      : MAKER_ID) :
    (opcode == `SFCH_WAKE_CMD)          ? SIG_ID : i_rd_data;
  wire next_oe = !cs_s && (next_state == SFCH_RUN) && out_phase;

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_so    <= 1'b0;
      o_so_oe <= 1'b0;
    end else begin
      o_so_oe <= next_oe;
      if (bit_fall && out_phase) begin
        o_so <= out_byte[3'h7 - bit_cnt];
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      state         <= SFCH_RUN;
      o_hold_active <= 1'b0;
    end else begin
      state         <= next_state;
      o_hold_active <= (next_state == SFCH_PAUSE);
    end
  end

  // -----------------------------------------------------------------
  // command execution at the select rise
  // -----------------------------------------------------------------
  // an aborted paused frame or a ragged last byte executes nothing
  wire execute  = cs_rise && (state == SFCH_RUN) && (bit_cnt == 3'h0);
  wire [2:0] need = exec_len(opcode);
  wire len_ok   = (need != 3'h0) && ((opcode == `SFCH_PAGE_WRITE_CMD) ?
                  (byte_cnt >= need) : (byte_cnt == need));
  wire set_wel  = execute && len_ok &&
                  (opcode == `SFCH_LATCH_SET_CMD);
  wire clr_wel  = (execute && len_ok &&
                   (opcode == `SFCH_LATCH_CLEAR_CMD)) ||
                  i_op_done;
  wire op_go    = execute && len_ok && !i_op_busy &&
                  (is_modify(opcode) ? o_write_latch_flag :
                   (opcode == `SFCH_DEEP_SLEEP_CMD) ||
                   (opcode == `SFCH_WAKE_CMD));

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_write_latch_flag <= 1'b0;
      o_op_start         <= 1'b0;
      o_op               <= '0;
    end else begin
      o_op_start <= op_go;
      if (set_wel) begin
        o_write_latch_flag <= 1'b1;
      end else if (clr_wel) begin
        o_write_latch_flag <= 1'b0;
      end
      if (op_go) begin
        o_op <= '{code: opcode, addr: addr};
      end
    end
  end

  // -----------------------------------------------------------------
  // received bytes toward the fifo; one byte of slack
  // -----------------------------------------------------------------
  logic       pend_valid;
  logic [7:0] pend_data;
  logic       fifo_ready;
  wire        push_req = byte_done && !out_phase;
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      pend_valid <= 1'b0;
      pend_data  <= '0;
      o_overrun  <= 1'b0;
    end else begin
      if (push_req) begin
        pend_valid <= 1'b1;
        pend_data  <= rx_byte;
      end else if (fifo_ready) begin
        pend_valid <= 1'b0;
      end
      if (push_req && pend_valid && !fifo_ready) begin
        o_overrun <= 1'b1;
      end else if (cs_fall) begin
        o_overrun <= 1'b0;
      end
    end
  end

  sfch_fifo #(.W(`SFCH_FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_sys_clk (i_sys_clk),
    .i_srst    (i_srst),
    .i_valid   (pend_valid),
    .o_ready   (fifo_ready),
    .i_data    (pend_data),
    .o_valid   (o_rx_valid),
    .i_ready   (i_rx_ready),
    .o_data    (o_rx_data)
  );

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);

  a_pause_entry: assert property (state == SFCH_RUN && !cs_s
    && !hold_s && !sclk_s |=> o_hold_active)
    else $error("pause not entered");
  a_pause_waits: assert property (state == SFCH_RUN && sclk_s
    |=> state == SFCH_RUN) else $error("pause began with clock high");
  a_pause_exit: assert property (state == SFCH_PAUSE && hold_s
    && !sclk_s |=> !o_hold_active) else $error("pause not ended");
  a_pause_holds: assert property (state == SFCH_PAUSE && !cs_s
    && sclk_s |=> state == SFCH_PAUSE) else $error("pause ended early");
  // enable is registered, so it trails the select rise by one cycle
  a_out_quiet: assert property (o_so_oe |-> state == SFCH_RUN
    && !$past(cs_s)) else $error("output driven while paused");
  a_pause_ignore: assert property (state == SFCH_PAUSE && !cs_s
    |=> bit_cnt == $past(bit_cnt) || cs_s)
    else $error("clock counted while paused");
  a_cs_reset: assert property (cs_rise |=> bit_cnt == 3'h0 &&
    byte_cnt == 3'h0 && !o_hold_active)
    else $error("interface not reset");
  a_latch_set: assert property (cs_rise && state == SFCH_RUN &&
    bit_cnt == 3'h0 && byte_cnt == 3'h1 && opcode == 8'h06
    |=> o_write_latch_flag) else $error("latch not set");
  a_latch_clear: assert property (cs_rise && state == SFCH_RUN &&
    bit_cnt == 3'h0 && byte_cnt == 3'h1 && opcode == 8'h04
    |=> !o_write_latch_flag) else $error("latch not cleared");
  a_done_clears: assert property (i_op_done && !set_wel
    |=> !o_write_latch_flag) else $error("latch kept on done");
  a_ragged_end: assert property (cs_rise && bit_cnt != 3'h0
    |=> !o_op_start) else $error("ragged command ran");
  a_ident_order: assert property (opcode == 8'h90 && out_phase &&
    out_idx == 3'h0 |-> out_byte == (addr[0] ? PART_ID[7:0] : MAKER_ID))
    else $error("ident order wrong");
  a_sample_rise: assert property (bit_rise && !cs_s
    |=> bit_cnt == $past(bit_cnt) + 3'h1 || cs_s)
    else $error("bit not sampled");

  c_pause: cover property (o_hold_active ##1 !o_hold_active);
  c_latch: cover property ($rose(o_write_latch_flag));
  c_op: cover property (o_op_start && is_modify(o_op.code));
  c_full: cover property (!fifo_ready);
endmodule
`default_nettype wire

// file: design/sfch_consts.svh
// constants for the serial flash command and pause front end
// Operation
// - a low pause input suspends all serial traffic without deselecting.
// - a pause never stops a status write, program or erase in progress.
// - a pause only counts while chip select stays low throughout.
// - the pause starts at the pause input fall, or at the next clock low.
// - the pause ends at the pause input rise, or at the next clock low.
// - while paused the output floats and input and clock are ignored.
// - chip select rising during a pause resets the interface logic.
// - opcode 06h sets the write latch flag.
// - opcode 04h clears the write latch flag.
// - the flag clears at reset and when a clear or modify completes.
// - for opcode 90h address 00h sends maker first, 01h part first.
// - short commands run only if select rises on a byte boundary.
// - bits are sampled on clock rise and shifted out on clock fall.
`ifndef SFCH_CONSTS_SVH
`define SFCH_CONSTS_SVH
`define SFCH_LATCH_SET_CMD      8'h06
`define SFCH_LATCH_CLEAR_CMD    8'h04
`define SFCH_STATUS_WRITE_CMD   8'h01
`define SFCH_JEDEC_IDENT_CMD    8'h9f
`define SFCH_STATUS_READ_CMD    8'h05
`define SFCH_READ_CMD           8'h03
`define SFCH_FAST_READ_CMD      8'h0b
`define SFCH_TWO_LINE_READ_CMD  8'h3b
`define SFCH_SMALL_WIPE_CMD     8'h20
`define SFCH_BLOCK_WIPE_CMD_A   8'h52
`define SFCH_BLOCK_WIPE_CMD_B   8'hd8
`define SFCH_CHIP_WIPE_CMD_A    8'h60
`define SFCH_CHIP_WIPE_CMD_B    8'hc7
`define SFCH_PAGE_WRITE_CMD     8'h02
`define SFCH_DEEP_SLEEP_CMD     8'hb9
`define SFCH_WAKE_CMD           8'hab
`define SFCH_MAKER_PART_ID_CMD  8'h90
`define SFCH_STAT_BUSY_BIT      0
`define SFCH_STAT_LATCH_BIT     1
`define SFCH_PINS_IDLE          4'h9
`define SFCH_FIFO_DEPTH         32
`define SFCH_FIFO_WIDTH         8
`endif

// file: design/sfch_pkg.sv
// types shared by the serial flash command and pause front end
package sfch_pkg;
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic si;
    logic hold_n;
  } sfch_pins_t;

  typedef struct packed {
    logic [7:0]  code;
    logic [23:0] addr;
  } sfch_op_t;

  typedef enum logic [1:0] {
    SFCH_RUN   = 2'b01,
    SFCH_PAUSE = 2'b10
  } sfch_state_t;
endpackage

// file: design/sfch_fifo.sv
// shift-register fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sfch_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 32
) (
  input  wire logic         i_sys_clk, // system clock
  input  wire logic         i_srst,    // sync reset, high
  input  wire logic         i_valid,   // fill side valid
  output logic              o_ready,   // fill side ready
  input  wire logic [W-1:0] i_data,    // fill side data
  output logic              o_valid,   // drain side valid
  input  wire logic         i_ready,   // drain side ready
  output logic [W-1:0]      o_data     // drain side data
);
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem [DEPTH];
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  wire           push = i_valid && o_ready;
  wire           pop  = o_valid && i_ready;

  assign o_ready    = (count != CW'(DEPTH));
  assign o_data     = mem[0];
  assign next_count = count + CW'(push) - CW'(pop);

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      count   <= '0;
      o_valid <= 1'b0;
    end else begin
      count   <= next_count;
      o_valid <= (next_count != '0);
    end
  end

  // -----------------------------------------------------------------
  // entries move toward the head on every pop
  // -----------------------------------------------------------------
  for (genvar g = 0; g < DEPTH; g++) begin : g_ent
    logic [W-1:0] upper;
    if (g == DEPTH - 1) begin : g_top
      assign upper = i_data;
    end else begin : g_mid
      assign upper = (push && count == CW'(g + 1)) ? i_data : mem[g+1];
    end
    always_ff @(posedge i_sys_clk) begin
      if (pop) begin
        mem[g] <= upper;
      end else if (push && count == CW'(g)) begin
        mem[g] <= i_data;
      end
    end
  end
endmodule
`default_nettype wire

// file: verif/sfch_host_model.sv
// host serial controller model driving the flash pins
`timescale 1ns/1ps
`default_nettype none
module sfch_host_model (
  output var sfch_pkg::sfch_pins_t o_pins, // pins toward the flash
  input  wire logic                i_so    // serial out of the flash
);
  import sfch_pkg::*;
  localparam realtime HALF = 62.5;

  initial o_pins = 4'h9;

  // ----------------------------------------------------------------
  // frame control
  // ----------------------------------------------------------------
  task automatic sel();
    o_pins.cs_n = 1'b0;
    #100;
  endtask

  // only called after whole bytes unless a test means a bad length
  task automatic desel();
    #100;
    o_pins.cs_n = 1'b1;
    // stale si would hide a design that still samples it
    o_pins.si = ~o_pins.si;
    #100;
  endtask

  // top n bits, msb first; si moves while sclk is low
  task automatic xfer_n(input int n, input logic [7:0] tx,
                        output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < n; i++) begin
      o_pins.si = tx[7-i];
      #HALF o_pins.sclk = 1'b1;
      rx = {rx[6:0], i_so};
      #HALF o_pins.sclk = 1'b0;
    end
  endtask

  task automatic set_sclk(input logic v);
    o_pins.sclk = v;
  endtask

  // raise before a new select after an abandoned pause
  task automatic set_hold(input logic v);
    o_pins.hold_n = v;
  endtask
endmodule
`default_nettype wire

// file: verif/sfch_front_test.sv
// self-checking bench for the serial flash command front end
`timescale 1ns/1ps
`default_nettype none
module sfch_front_test;
  import sfch_pkg::*;
  localparam logic [7:0] MAKER = 8'h5a; // arbitrary value

  logic        i_sys_clk  = 1'b0;
  logic        i_srst     = 1'b1;
  logic        i_op_busy  = 1'b0;
  logic        i_op_done  = 1'b0;
  logic        i_rx_ready = 1'b1;
  sfch_pins_t  pins;
  logic        o_so, o_so_oe, o_write_latch_flag, o_hold_active;
  logic        o_op_start, o_rx_valid, o_overrun;
  sfch_op_t    o_op, last_op;
  logic [23:0] o_rd_addr;
  logic [7:0]  o_rx_data, rx;
  int          mismatches = 0;
  int          samples_checked = 0;
  int          starts = 0;

  always #5 i_sys_clk = ~i_sys_clk;

  always @(posedge i_sys_clk) begin
    if (o_op_start === 1'b1) begin
      starts++;
      last_op = o_op;
    end
  end

  sfch_front #(.MAKER_ID(MAKER)) sfch_front_inst (
    .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_pins(pins),
    .i_status(8'h00), .i_op_busy(i_op_busy), .i_op_done(i_op_done),
    .i_rd_data(o_rd_addr[7:0]), .i_rx_ready(i_rx_ready), .o_so(o_so),
    .o_so_oe(o_so_oe), .o_write_latch_flag(o_write_latch_flag),
    .o_hold_active(o_hold_active), .o_op_start(o_op_start), .o_op(o_op),
    .o_rd_addr(o_rd_addr), .o_rx_valid(o_rx_valid),
    .o_rx_data(o_rx_data), .o_overrun(o_overrun));

  // a released output shows the inverse so late sampling is caught
  sfch_host_model sfch_host_model_inst (.o_pins(pins),
    .i_so(o_so_oe ? o_so : ~o_so));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask

  task automatic sel();
    sfch_host_model_inst.sel();
  endtask

  task automatic desel();
    sfch_host_model_inst.desel();
  endtask

  task automatic bits(input int n, input logic [7:0] v);
    sfch_host_model_inst.xfer_n(n, v, rx);
  endtask

  task automatic hold(input logic v);
    sfch_host_model_inst.set_hold(v);
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t %s seen %h expected %h",
               $time, what, seen, exp);
    end
  endtask

  task automatic frame(input logic [7:0] q[$]);
    sel();
    foreach (q[i]) bits(8, q[i]);
    desel();
    tick(2);
  endtask

  task automatic finish_op();
    i_op_busy = 1'b1;
    tick(3);
    i_op_done = 1'b1;
    tick(1);
    i_op_done = 1'b0;
    i_op_busy = 1'b0;
    tick(2);
  endtask

  task automatic complete_run();
    $display("mismatches %0d samples_checked %0d", mismatches,
             samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_latch();
    frame('{8'h06});
    check(o_write_latch_flag, 1'b1, "set");
    frame('{8'h05, 8'h00});
    check(rx[1:0], 2'b10, "status bits");
    frame('{8'h04});
    check(o_write_latch_flag, 1'b0, "clear");
    sel();
    bits(8, 8'h06);
    bits(1, 8'h00);
    desel();
    tick(2);
    check(o_write_latch_flag, 1'b0, "odd length");
  endtask

  task automatic t_modify();
    // only opcodes of the defined set are sent
    logic [7:0] code [6] = '{8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7, 8'h01};
    int n0;
    n0 = starts;
    frame('{8'h20, 8'h12, 8'h34, 8'h56});
    check(starts, n0, "no latch");
    foreach (code[i]) begin
      frame('{8'h06});
      if (i < 3)
        frame('{code[i], 8'h12, 8'h34, 8'h56});
      else if (i < 5)
        frame('{code[i]});
      else
        frame('{code[i], 8'h3c});
      check(starts, n0 + i + 1, "accepted");
      check(last_op.code, code[i], "code");
      if (i < 3)
        check(last_op.addr, 24'h123456, "addr");
      check(o_write_latch_flag, 1'b1, "flag in op");
      finish_op();
      check(o_write_latch_flag, 1'b0, "flag after op");
    end
    frame('{8'hb9});
    frame('{8'hab});
    check(starts, n0 + 8, "sleep and wake");
    i_op_busy = 1'b1;
    frame('{8'hb9});
    check(starts, n0 + 8, "busy refused");
    i_op_busy = 1'b0;
  endtask

  task automatic t_read();
    frame('{8'h03, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00});
    check(rx, 8'h11, "read data");
    check(o_rd_addr, 24'h000012, "read addr");
    sel();
    bits(8, 8'h0b);
    for (int k = 0; k < 5; k++)
      bits(8, (k == 2) ? 8'h20 : 8'h00);
    check(o_so_oe, 1'b1, "so driven");
    desel();
    tick(2);
    check(rx, 8'h20, "fast read dummy");
    check(o_so_oe, 1'b0, "so released");
  endtask

  task automatic t_ident();
    frame('{8'h90, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    check(rx, MAKER, "maker first");
    frame('{8'h90, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00});
    check(rx, MAKER, "part first");
    frame('{8'h9f, 8'h00});
    check(rx, MAKER, "ident");
  endtask

  task automatic t_hold();
    sel();
    bits(4, 8'h06);
    hold(1'b0);
    tick(6);
    check(o_hold_active, 1'b1, "pause clk low");
    check(o_so_oe, 1'b0, "so floats");
    bits(8, 8'hff);
    hold(1'b1);
    tick(6);
    check(o_hold_active, 1'b0, "resume clk low");
    bits(4, 8'h60);
    desel();
    tick(2);
    check(o_write_latch_flag, 1'b1, "split byte");
    frame('{8'h20, 8'h00, 8'h10, 8'h00});
    sel();
    sfch_host_model_inst.set_sclk(1'b1);
    hold(1'b0);
    tick(8);
    check(o_hold_active, 1'b0, "wait clk low");
    sfch_host_model_inst.set_sclk(1'b0);
    tick(6);
    check(o_hold_active, 1'b1, "pause late");
    finish_op();
    check(o_write_latch_flag, 1'b0, "op ends paused");
    sfch_host_model_inst.set_sclk(1'b1);
    tick(8);
    hold(1'b1);
    tick(8);
    check(o_hold_active, 1'b1, "still paused");
    sfch_host_model_inst.set_sclk(1'b0);
    tick(6);
    check(o_hold_active, 1'b0, "resume late");
    desel();
    sel();
    bits(8, 8'h06);
    hold(1'b0);
    tick(6);
    desel();
    tick(2);
    check(o_write_latch_flag, 1'b0, "abandoned");
    hold(1'b1);
    tick(4);
    frame('{8'h06});
    check(o_write_latch_flag, 1'b1, "restart");
    frame('{8'h04});
  endtask

  task automatic t_fifo();
    i_rx_ready = 1'b0;
    sel();
    for (int k = 0; k < 34; k++)
      bits(8, (k == 0) ? 8'h02 : k[7:0]);
    tick(4);
    check(o_overrun, 1'b1, "overrun");
    desel();
    for (int k = 0; k < 33; k++) begin
      for (int n = 0; n < 10 && o_rx_valid !== 1'b1; n++)
        tick(1);
      check(o_rx_valid, 1'b1, "fifo valid");
      if (o_rx_valid !== 1'b1)
        complete_run();
      // on overrun the slack byte is replaced by the newest one
      check(o_rx_data, (k == 0) ? 8'h02 : (k == 32) ? 8'h21 : k[7:0],
            "fifo data");
      i_rx_ready = 1'b1;
      tick(1);
      i_rx_ready = 1'b0;
      tick(1);
    end
    tick(4);
    check(o_rx_valid, 1'b0, "fifo empty");
    i_rx_ready = 1'b1;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    tick(4);
    i_srst = 1'b0;
    tick(4);
    check(o_write_latch_flag, 1'b0, "reset flag");
    t_latch();
    t_modify();
    t_ident();
    t_read();
    t_hold();
    t_fifo();
    complete_run();
  end

  initial begin
    #1000000;
    mismatches++;
    $display("CHECK FAILED t=%0t run hung", $time);
    complete_run();
  end
endmodule
`default_nettype wire
